// ===== pmdd_panel.sv
// Front-panel monitor display, fault view, jog and digital I/O diagnosis logic.
`timescale 1ns/10ps
`include "pmdd_consts.svh"
module pmdd_panel
  import pmdd_pkg::*;
#(
  parameter int unsigned SYMBOL_CYCLES = `PMDD_SYM_NS / `PMDD_CLK_NS
)(
  input  wire logic        clk_i,                  // System clock, 100 MHz.
  input  wire logic        reset_n_i,              // Synchronous reset, active low.
  input  wire logic        key_set_i,              // Set key pin, high while pressed.
  input  wire logic        key_up_i,               // Up key pin, high while pressed.
  input  wire logic        key_down_i,             // Down key pin, high while pressed.
  input  wire logic        key_mode_i,             // Mode key pin, leaves fault and jog views.
  input  wire logic [4:0]  input_line_i,           // Digital input pins one to five.
  input  wire logic        servo_on_i,             // Drive is in servo-on state.
  input  wire logic [1:0]  normal_do_i,            // Normal function values of outputs.
  input  wire logic [7:0]  monitor_select_param_i, // Stored monitor selector.
  input  wire logic        param_mode_i,           // Panel is in parameter mode.
  input  wire logic [7:0]  param_sel_i,            // Selected diagnosis parameter index.
  input  wire logic [1:0]  diag_mode_i,            // 1 input diagnosis, 2 output diagnosis.
  input  wire logic        edit_active_i,          // A parameter value is being edited.
  input  wire logic [31:0] edit_value_i,           // Value being edited.
  input  wire logic        edit_is32_i,            // Edited value is 32 bits.
  input  wire logic        edit_hex_i,             // Edited value is shown in hex.
  input  wire logic        view_hex_i,             // Live 32-bit values shown in hex.
  input  wire logic        view_high_i,            // Show high half of 32-bit values.
  input  wire logic        cmd_wr_i,               // Special command write strobe.
  input  wire logic [15:0] cmd_value_i,            // Special command value.
  input  wire logic        mask_wr_i,              // Forced output mask write strobe.
  input  wire logic [15:0] mask_value_i,           // Forced output mask value.
  input  wire logic [15:0] fault_record_i,         // Stored fault entry at fault_index_o.
  input  wire logic [7:0]  resonance_one_i,        // First resonance, Hz.
  input  wire logic [7:0]  resonance_two_i,        // Second resonance, Hz.
  input  wire logic [15:0] inertia_x10_i,          // Inertia ratio times ten.
  input  wire logic [31:0] encoder_index_pulse_i,  // Signed pulses from index.
  input  wire logic [31:0] mapping_value_one_i,    // Mapping value one.
  input  wire logic [31:0] mapping_value_two_i,    // Mapping value two.
  input  wire logic [31:0] mapping_value_three_i,  // Mapping value three.
  input  wire logic [31:0] monitor_value_one_i,    // Monitor variable one.
  input  wire logic [31:0] monitor_value_two_i,    // Monitor variable two.
  input  wire logic [31:0] monitor_value_three_i,  // Monitor variable three.
  input  wire logic [31:0] monitor_value_four_i,   // Monitor variable four.
  input  wire logic [31:0] misc_value_i,           // Value for any other selector code.
  output logic      [24:0] disp_digit_o,           // Five 5-bit digit codes, digit 0 right.
  output logic      [4:0]  disp_dp_o,              // Decimal points, bit 0 right.
  output logic             symbol_active_o,        // Selector symbol is being shown.
  output logic      [7:0]  monitor_sel_o,          // Current monitor selector.
  output logic      [2:0]  fault_index_o,          // Fault entry being viewed.
  output logic             jog_symbol_o,           // Jog symbol is shown.
  output logic      [15:0] jog_speed_o,            // Jog speed, r/min.
  output logic             jog_fwd_o,              // Drive motor forward.
  output logic             jog_rev_o,              // Drive motor in reverse.
  output logic             forced_mode_o,          // Forced output mode active.
  output logic      [1:0]  output_line_o           // Digital outputs one and two.
);
  pmdd_regs_t  r;
  pmdd_regs_t  n;
  logic        set_e;
  logic        up_e;
  logic        dn_e;
  logic        md_e;
  logic        conv_done;
  logic [39:0] bcd;
  logic [31:0] src_val;
  logic [31:0] mag;
  logic        src_hex;
  logic        src_32;
  logic        src_high;
  logic        src_sgn;
  logic        src_frac;
  logic        neg;
  logic [2:0]  base;

  pmdd_bin2bcd u_conv (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (!r.busy),
    .bin_i     (mag),
    .busy_o    (),
    .done_o    (conv_done),
    .bcd_o     (bcd)
  );

  always_comb begin
    n = r;
    n.set_s = {r.set_s[1:0], key_set_i};
    n.up_s  = {r.up_s[1:0], key_up_i};
    n.dn_s  = {r.dn_s[1:0], key_down_i};
    n.md_s  = {r.md_s[1:0], key_mode_i};
    n.di_s1 = input_line_i;
    n.di_s2 = r.di_s1;
    set_e = r.set_s[1] & ~r.set_s[2];
    up_e  = r.up_s[1] & ~r.up_s[2];
    dn_e  = r.dn_s[1] & ~r.dn_s[2];
    md_e  = r.md_s[1] & ~r.md_s[2];

    // The stored selector is caught on the first cycle after reset, then its symbol stays up for SYMBOL_CYCLES cycles.
    if (!r.init) begin
      n.init    = 1'b1;
      n.msel    = monitor_select_param_i;
      n.sym_on  = 1'b1;
      n.sym_cnt = SYMBOL_CYCLES;
    end else if (r.sym_on) begin
      n.sym_cnt = r.sym_cnt - 32'h1;
      if (r.sym_cnt <= 32'h1) begin
        n.sym_on = 1'b0;
      end
    end

    // Forced mode lives only in a flip-flop, so reset clears it.
    if (cmd_wr_i && cmd_value_i == `PMDD_CMD_FORCE) begin
      n.forced = 1'b1;
    end else if (cmd_wr_i && cmd_value_i == `PMDD_CMD_NORMAL) begin
      n.forced = 1'b0;
    end
    if (mask_wr_i) begin
      n.mask = mask_value_i[1:0];
    end
    n.dout = r.forced ? r.mask : normal_do_i;

    n.fwd = 1'b0;
    n.rev = 1'b0;
    case (r.st)
      PMDD_MON: begin
        if (param_mode_i && set_e) begin
          if (param_sel_i <= `PMDD_PSEL_FLT_LAST) begin
            n.st   = PMDD_FAULT;
            n.fidx = param_sel_i[2:0];
          end else if (param_sel_i == `PMDD_PSEL_JOG) begin
            n.st = PMDD_JOG_SPD;
          end
        end else if (!param_mode_i && !edit_active_i && !r.sym_on) begin
          if (up_e && r.msel < `PMDD_CODE_MAX) begin
            n.msel = r.msel + 8'h1;
          end else if (dn_e && r.msel != 8'h0) begin
            n.msel = r.msel - 8'h1;
          end
        end
      end
      PMDD_FAULT: begin
        if (set_e || md_e) begin
          n.st = PMDD_MON;
        end
      end
      PMDD_JOG_SPD: begin
        if (md_e) begin
          n.st = PMDD_MON;
        end else if (set_e) begin
          n.st      = PMDD_JOG_RUN;
          n.jog_sym = 1'b1;
        end else if (up_e && r.jog_spd < `PMDD_JOG_MAX) begin
          n.jog_spd = r.jog_spd + 16'h1;
        end else if (dn_e && r.jog_spd != 16'h0) begin
          n.jog_spd = r.jog_spd - 16'h1;
        end
      end
      PMDD_JOG_RUN: begin
        if (set_e || md_e) begin
          n.st      = PMDD_MON;
          n.jog_sym = 1'b0;
        end else begin
          // Both keys held cancel each other rather than pick a direction.
          n.fwd = r.up_s[1] & ~r.dn_s[1] & servo_on_i;
          n.rev = r.dn_s[1] & ~r.up_s[1] & servo_on_i;
        end
      end
      default: begin
        n.st = PMDD_MON;
      end
    endcase

    // Pick what the digits show; the formats below are shared by every source.
    src_val  = misc_value_i;
    src_hex  = view_hex_i;
    src_32   = 1'b1;
    src_high = view_high_i;
    src_sgn  = 1'b1;
    src_frac = 1'b0;
    if (edit_active_i) begin
      src_val  = edit_value_i;
      src_hex  = edit_hex_i;
      src_32   = edit_is32_i;
    end else if (r.st == PMDD_FAULT) begin
      src_val = {16'h0, fault_record_i};
      src_hex = 1'b1;
      src_32  = 1'b0;
    end else if (param_mode_i && param_sel_i == `PMDD_PSEL_MASK) begin
      src_val = {30'h0, r.mask};
      src_hex = 1'b1;
      src_32  = 1'b0;
    end else if (r.st == PMDD_JOG_SPD) begin
      src_val = {16'h0, r.jog_spd};
      src_hex = 1'b0;
      src_32  = 1'b0;
      src_sgn = 1'b0;
    end else if (diag_mode_i == `PMDD_DIAG_IN) begin
      src_val = {27'h0, r.di_s2};
      src_hex = 1'b1;
      src_32  = 1'b0;
    end else if (diag_mode_i == `PMDD_DIAG_OUT) begin
      src_val = {30'h0, r.dout};
      src_hex = 1'b1;
      src_32  = 1'b0;
    end else begin
      case (r.msel)
        `PMDD_CODE_INERTIA: begin
          src_val  = {16'h0, inertia_x10_i};
          src_hex  = 1'b0;
          src_32   = 1'b0;
          src_sgn  = 1'b0;
          src_frac = 1'b1;
        end
        `PMDD_CODE_RESON: begin
          src_val = {16'h0, resonance_two_i, resonance_one_i};
          src_hex = 1'b1;
          src_32  = 1'b0;
        end
        `PMDD_CODE_ENCODER: src_val = encoder_index_pulse_i;
        `PMDD_CODE_MAP1:    src_val = mapping_value_one_i;
        `PMDD_CODE_MAP2:    src_val = mapping_value_two_i;
        `PMDD_CODE_MAP3:    src_val = mapping_value_three_i;
        `PMDD_CODE_MON1:    src_val = monitor_value_one_i;
        `PMDD_CODE_MON2:    src_val = monitor_value_two_i;
        `PMDD_CODE_MON3:    src_val = monitor_value_three_i;
        `PMDD_CODE_MON4:    src_val = monitor_value_four_i;
        default:            src_val = misc_value_i;
      endcase
    end
    neg = src_sgn & ~src_hex & (src_32 ? src_val[31] : src_val[15]);
    if (src_32) begin
      mag = neg ? 32'(-src_val) : src_val;
    end else begin
      mag = neg ? {16'h0, 16'(-src_val[15:0])} : {16'h0, src_val[15:0]};
    end

    // A new value is captured whenever the converter is free, so the view refreshes continuously.
    base = (r.c_32 && r.c_high) ? 3'(`PMDD_HALF_DIGITS) : 3'h0;
    if (!r.busy) begin
      n.busy   = 1'b1;
      n.c_val  = src_val;
      n.c_hex  = src_hex;
      n.c_32   = src_32;
      n.c_high = src_high;
      n.c_neg  = neg;
      n.c_frac = src_frac;
    end else if (conv_done) begin
      n.busy = 1'b0;
      if (r.c_hex) begin
        n.dp = 5'h0;
        if (!r.c_32) begin
          n.dig = {`PMDD_DIG_BLANK, 1'b0, r.c_val[15:12], 1'b0, r.c_val[11:8],
                   1'b0, r.c_val[7:4], 1'b0, r.c_val[3:0]};
        end else if (r.c_high) begin
          n.dig = {`PMDD_DIG_H, 1'b0, r.c_val[31:28], 1'b0, r.c_val[27:24],
                   1'b0, r.c_val[23:20], 1'b0, r.c_val[19:16]};
        end else begin
          n.dig = {`PMDD_DIG_L, 1'b0, r.c_val[15:12], 1'b0, r.c_val[11:8],
                   1'b0, r.c_val[7:4], 1'b0, r.c_val[3:0]};
        end
      end else begin
        for (int i = 0; i < `PMDD_HALF_DIGITS; i++) begin
          n.dig[5 * i +: 5] = {1'b0, bcd[4 * (32'(base) + i) +: 4]};
        end
        n.dp = {r.c_neg, r.c_neg, 1'b0, r.c_frac, r.c_32 & r.c_high};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r         <= '0;
      r.st      <= PMDD_MON;
      r.jog_spd <= `PMDD_JOG_DEFAULT;
      r.dig     <= {5{`PMDD_DIG_BLANK}};
    end else begin
      r <= n;
    end
  end

  assign disp_digit_o    = r.dig;
  assign disp_dp_o       = r.dp;
  assign symbol_active_o = r.sym_on;
  assign monitor_sel_o   = r.msel;
  assign fault_index_o   = r.fidx;
  assign jog_symbol_o    = r.jog_sym;
  assign jog_speed_o     = r.jog_spd;
  assign jog_fwd_o       = r.fwd;
  assign jog_rev_o       = r.rev;
  assign forced_mode_o   = r.forced;
  assign output_line_o   = r.dout;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_jog_servo;
    (jog_fwd_o || jog_rev_o) |-> $past(servo_on_i);
  endproperty
  a_jog_servo: assert property (p_jog_servo) else $error("Jog motion without servo on.");

  property p_jog_fwd;
    (r.st == PMDD_JOG_RUN && !set_e && !md_e && r.up_s[1] && !r.dn_s[1] && servo_on_i) |=> jog_fwd_o;
  endproperty
  a_jog_fwd: assert property (p_jog_fwd) else $error("Held up key did not drive forward.");

  property p_jog_stop;
    (!r.up_s[1] && !r.dn_s[1]) |=> (!jog_fwd_o && !jog_rev_o);
  endproperty
  a_jog_stop: assert property (p_jog_stop) else $error("Jog did not stop on key release.");

  property p_jog_symbol;
    (r.st == PMDD_JOG_SPD && set_e && !md_e) |=> (jog_symbol_o && r.st == PMDD_JOG_RUN);
  endproperty
  a_jog_symbol: assert property (p_jog_symbol) else $error("Second set did not enter jog.");

  property p_force_on;
    (cmd_wr_i && cmd_value_i == `PMDD_CMD_FORCE) |=> forced_mode_o ##1 (output_line_o == $past(r.mask));
  endproperty
  a_force_on: assert property (p_force_on) else $error("Forced output mode not applied.");

  property p_force_off;
    (cmd_wr_i && cmd_value_i == `PMDD_CMD_NORMAL) |=> !forced_mode_o ##1 (output_line_o == $past(normal_do_i));
  endproperty
  a_force_off: assert property (p_force_off) else $error("Forced output mode not released.");

  property p_powerup_sel;
    !r.init |=> (monitor_sel_o == $past(monitor_select_param_i)) && symbol_active_o;
  endproperty
  a_powerup_sel: assert property (p_powerup_sel) else $error("Selector not loaded at power-up.");

  property p_neg_points;
    (r.busy && conv_done && !r.c_hex) |=> (disp_dp_o[4:3] == {2{$past(r.c_neg)}});
  endproperty
  a_neg_points: assert property (p_neg_points) else $error("Negative sign points wrong.");

  property p_hex_blank;
    (r.busy && conv_done && r.c_hex && !r.c_32) |=> (disp_digit_o[24:20] == `PMDD_DIG_BLANK && disp_dp_o == 5'h0);
  endproperty
  a_hex_blank: assert property (p_hex_blank) else $error("Hex leftmost digit not blank.");

  c_jog_run: cover property (jog_fwd_o ##1 jog_fwd_o);
  c_forced: cover property (forced_mode_o && output_line_o != normal_do_i);
  c_fault: cover property (r.st == PMDD_FAULT ##1 r.st == PMDD_MON);
  c_dec_high: cover property (disp_dp_o[0] && !disp_dp_o[4]);
endmodule

// ===== pmdd_consts.svh
// Constants for the panel monitor display and diagnosis block.
// How it works
// - Code 17 shows both resonance frequency bytes.
// - Code 15 shows inertia ratio, one decimal.
// - Code 18 shows encoder pulses from index.
// - Codes 19-21 show the three mapping values.
// - Codes 23-26 show monitor values one-four.
// - Decimal 16-bit: five digits, leading zeros.
// - Hex 16-bit: four digits, leftmost blank.
// - Decimal 32-bit: high/low halves, high dotted.
// - Hex 32-bit: h upper half, L lower.
// - Decimal negative lights two left points.
// - Editing uses the same number rendering.
// - Set on fault-history parameter shows entry.
// - Jog entry shows speed, default 20 r/min.
// - Second set shows jog symbol, runs jog.
// - Held up forward, held down reverse.
// - Jog motion only while servo on.
// - Command 406 enables forced output mode.
// - Mask bit 0 drives output one.
// - Forced mode lost at reset or 400.
// - Forced mask shown hex, fifth digit blank.
// - Input diagnosis shows inputs as hex bits.
// - Output diagnosis shows outputs as hex bits.
// - Power-up selector from stored parameter, symbol first.
`ifndef PMDD_CONSTS_SVH
`define PMDD_CONSTS_SVH
`define PMDD_CLK_NS        32'd10
`define PMDD_SYM_NS        32'd1000000000
`define PMDD_CODE_INERTIA  8'h0f
`define PMDD_CODE_RESON    8'h11
`define PMDD_CODE_ENCODER  8'h12
`define PMDD_CODE_MAP1     8'h13
`define PMDD_CODE_MAP2     8'h14
`define PMDD_CODE_MAP3     8'h15
`define PMDD_CODE_MON1     8'h17
`define PMDD_CODE_MON2     8'h18
`define PMDD_CODE_MON3     8'h19
`define PMDD_CODE_MON4     8'h1a
`define PMDD_CODE_MAX      8'h1a
`define PMDD_PSEL_FLT_LAST 8'h04
`define PMDD_PSEL_JOG      8'h05
`define PMDD_PSEL_MASK     8'h06
`define PMDD_CMD_FORCE     16'h0196
`define PMDD_CMD_NORMAL    16'h0190
`define PMDD_JOG_DEFAULT   16'h0014
`define PMDD_JOG_MAX       16'h1388
`define PMDD_DIAG_IN       2'h1
`define PMDD_DIAG_OUT      2'h2
`define PMDD_DIG_BLANK     5'h10
`define PMDD_DIG_H         5'h11
`define PMDD_DIG_L         5'h12
`define PMDD_HALF_DIGITS   5
`define PMDD_CONV_BITS     6'h20
`endif

// ===== pmdd_pkg.sv
// Types shared by the panel monitor display and diagnosis block.
package pmdd_pkg;
  typedef enum logic [1:0] {
    PMDD_MON     = 2'b00,
    PMDD_FAULT   = 2'b01,
    PMDD_JOG_SPD = 2'b10,
    PMDD_JOG_RUN = 2'b11
  } pmdd_state_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [71:0] sh;
    logic [39:0] bcd;
  } pmdd_conv_t;

  typedef struct packed {
    logic [2:0]  set_s;
    logic [2:0]  up_s;
    logic [2:0]  dn_s;
    logic [2:0]  md_s;
    logic [4:0]  di_s1;
    logic [4:0]  di_s2;
    logic        init;
    logic        sym_on;
    logic [31:0] sym_cnt;
    logic [7:0]  msel;
    pmdd_state_t st;
    logic [15:0] jog_spd;
    logic        jog_sym;
    logic        fwd;
    logic        rev;
    logic        forced;
    logic [1:0]  mask;
    logic [1:0]  dout;
    logic [2:0]  fidx;
    logic        busy;
    logic        c_hex;
    logic        c_32;
    logic        c_high;
    logic        c_neg;
    logic        c_frac;
    logic [31:0] c_val;
    logic [24:0] dig;
    logic [4:0]  dp;
  } pmdd_regs_t;
endpackage

// ===== pmdd_bin2bcd.sv
// Serial binary to ten-digit BCD converter, one bit per clock.
`timescale 1ns/10ps
`include "pmdd_consts.svh"
module pmdd_bin2bcd
  import pmdd_pkg::*;
(
  input  wire logic        clk_i,      // System clock.
  input  wire logic        reset_n_i,  // Synchronous reset, active low.
  input  wire logic        start_i,    // Starts a conversion when idle.
  input  wire logic [31:0] bin_i,      // Unsigned value to convert.
  output logic             busy_o,     // Conversion in progress.
  output logic             done_o,     // One-cycle pulse, result valid.
  output logic      [39:0] bcd_o       // Ten BCD digits, digit 0 lowest.
);
  pmdd_conv_t r;
  pmdd_conv_t n;
  logic [71:0] t;

  always_comb begin
    n = r;
    t = r.sh;
    n.done = 1'b0;
    if (!r.busy) begin
      if (start_i) begin
        n.busy = 1'b1;
        n.sh   = {40'h0, bin_i};
        n.cnt  = `PMDD_CONV_BITS;
      end
    end else begin
      // Shift-and-add-three keeps every nibble a legal decimal digit.
      for (int i = 0; i < 10; i++) begin
        if (t[32 + 4 * i +: 4] >= 4'h5) begin
          t[32 + 4 * i +: 4] = t[32 + 4 * i +: 4] + 4'h3;
        end
      end
      t = {t[70:0], 1'b0};
      n.sh  = t;
      n.cnt = r.cnt - 6'h1;
      if (r.cnt == 6'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.bcd  = t[71:32];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy_o = r.busy;
  assign done_o = r.done;
  assign bcd_o  = r.bcd;
endmodule

// ===== pmdd_keypad_model.sv
// Keypad model standing for the person at the front panel.
`timescale 1ns/10ps
module pmdd_keypad_model (
  input  wire logic clk_i,       // System clock.
  output logic      key_set_o,   // Set key, high while pressed.
  output logic      key_up_o,    // Up key, high while pressed.
  output logic      key_down_o,  // Down key, high while pressed.
  output logic      key_mode_o   // Mode key, high while pressed.
);
  logic [3:0] keys_reg = 4'h0;
  assign {key_mode_o, key_down_o, key_up_o, key_set_o} = keys_reg;
  // A human key level lasts far longer than the two-stage synchroniser plus edge detect.
  task automatic put(input int k, input logic v);
    @(posedge clk_i);
    #1;
    keys_reg[k] = v;
    repeat (6) @(posedge clk_i);
    #1;
  endtask
endmodule

// ===== tb_pmdd_panel.sv
// Self-checking testbench for the panel monitor display and diagnosis block.
`timescale 1ns/10ps
module tb_pmdd_panel;
  localparam logic [4:0] B = 5'h10;
  logic        clk_i, reset_n_i, servo_on_i, param_mode_i, edit_active_i, edit_is32_i, edit_hex_i;
  logic        view_hex_i, view_high_i, cmd_wr_i, mask_wr_i, key_set_i, key_up_i, key_down_i, key_mode_i;
  logic        symbol_active_o, jog_symbol_o, jog_fwd_o, jog_rev_o, forced_mode_o;
  logic [4:0]  input_line_i, disp_dp_o;
  logic [1:0]  normal_do_i, diag_mode_i, output_line_o;
  logic [7:0]  monitor_select_param_i, param_sel_i, resonance_one_i, resonance_two_i, monitor_sel_o;
  logic [15:0] cmd_value_i, mask_value_i, fault_record_i, inertia_x10_i, jog_speed_o;
  logic [31:0] edit_value_i, encoder_index_pulse_i, misc_value_i, mapping_value_one_i, mapping_value_two_i;
  logic [31:0] mapping_value_three_i, monitor_value_one_i, monitor_value_two_i, monitor_value_three_i;
  logic [31:0] monitor_value_four_i;
  logic [24:0] disp_digit_o;
  logic [2:0]  fault_index_o;
  int          err_count = 0;
  int          checks = 0;
  pmdd_keypad_model kp (.clk_i, .key_set_o(key_set_i), .key_up_o(key_up_i), .key_down_o(key_down_i),
    .key_mode_o(key_mode_i));
  pmdd_panel #(.SYMBOL_CYCLES(20)) DUT (.clk_i, .reset_n_i, .key_set_i, .key_up_i, .key_down_i, .key_mode_i,
    .input_line_i, .servo_on_i, .normal_do_i, .monitor_select_param_i, .param_mode_i, .param_sel_i,
    .diag_mode_i, .edit_active_i, .edit_value_i, .edit_is32_i, .edit_hex_i, .view_hex_i, .view_high_i,
    .cmd_wr_i, .cmd_value_i, .mask_wr_i, .mask_value_i, .fault_record_i, .resonance_one_i, .resonance_two_i,
    .inertia_x10_i, .encoder_index_pulse_i, .mapping_value_one_i, .mapping_value_two_i, .mapping_value_three_i,
    .monitor_value_one_i, .monitor_value_two_i, .monitor_value_three_i, .monitor_value_four_i, .misc_value_i,
    .disp_digit_o, .disp_dp_o, .symbol_active_o, .monitor_sel_o, .fault_index_o, .jog_symbol_o, .jog_speed_o,
    .jog_fwd_o, .jog_rev_o, .forced_mode_o, .output_line_o);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // A full render loop is 34 cycles, so 80 covers any capture phase.
  task automatic disp(input string nm, input logic [24:0] d, input logic [4:0] p);
    tick(80);
    chk(nm, disp_digit_o, d);
    chk(nm, disp_dp_o, p);
  endtask
  task automatic do_reset(input logic [7:0] code);
    reset_n_i = 1'b0;
    monitor_select_param_i = code;
    tick(8);
    chk("digits_rst", disp_digit_o, {B, B, B, B, B});
    chk("jog_rst", jog_speed_o, 16'h0014);
    reset_n_i = 1'b1;
    tick(2);
    chk("msel", monitor_sel_o, code);
    chk("sym_on", symbol_active_o, 1'b1);
    tick(100);
    chk("sym_off", symbol_active_o, 1'b0);
  endtask
  task automatic wr(input logic m, input logic [15:0] v);
    {cmd_value_i, mask_value_i, cmd_wr_i, mask_wr_i} = {v, v, ~m, m};
    tick(1);
    {cmd_wr_i, mask_wr_i} = 2'b00;
    tick(3);
  endtask
  task automatic press(input int k);
    kp.put(k, 1'b1);
    kp.put(k, 1'b0);
  endtask
  task automatic t_monitor();
    do_reset(8'h0f);
    disp("inertia", {5'h0, 5'h0, 5'h1, 5'h3, 5'h0}, 5'h02);
    do_reset(8'h11);
    disp("reson", {B, 5'h1, 5'h2, 5'h3, 5'h4}, 5'h00);
    do_reset(8'h12);
    disp("enc_lo", {5'h6, 5'h7, 5'h8, 5'h9, 5'h0}, 5'h00);
    view_high_i = 1'b1;
    disp("enc_hi", {5'h1, 5'h2, 5'h3, 5'h4, 5'h5}, 5'h01);
    encoder_index_pulse_i = 32'hffffec78;
    view_high_i = 1'b0;
    disp("enc_neg", {5'h0, 5'h5, 5'h0, 5'h0, 5'h0}, 5'h18);
    view_hex_i = 1'b1;
    for (logic [7:0] c = 8'h13; c <= 8'h1a; c++) begin
      if (c != 8'h16) begin
        do_reset(c);
        view_high_i = 1'b0;
        disp("map_lo", {5'h12, 5'h0, 5'h0, 5'h1, 1'b0, c[3:0]}, 5'h00);
        view_high_i = 1'b1;
        disp("map_hi", {5'h11, 5'h1, 5'h2, 5'h3, 5'h4}, 5'h00);
      end
    end
  endtask
  task automatic t_edit();
    edit_active_i = 1'b1;
    disp("ed_dec", {5'h0, 5'h1, 5'h2, 5'h3, 5'h4}, 5'h00);
    edit_value_i = 32'hffffcfc7;
    disp("ed_neg", {5'h1, 5'h2, 5'h3, 5'h4, 5'h5}, 5'h18);
    edit_hex_i = 1'b1;
    disp("ed_hexn", {B, 5'hc, 5'hf, 5'hc, 5'h7}, 5'h00);
    edit_is32_i = 1'b1;
    disp("ed_hex32", {5'h11, 5'hf, 5'hf, 5'hf, 5'hf}, 5'h00);
    edit_active_i = 1'b0;
    diag_mode_i = 2'h1;
    disp("di", {B, 5'h0, 5'h0, 5'h1, 5'he}, 5'h00);
    diag_mode_i = 2'h2;
    disp("do", {B, 5'h0, 5'h0, 5'h0, 5'h3}, 5'h00);
  endtask
  task automatic t_force();
    normal_do_i = 2'b10;
    wr(1'b0, 16'h0196);
    chk("forced", forced_mode_o, 1'b1);
    wr(1'b1, 16'hfff5);
    chk("out_mask", output_line_o, 2'b01);
    {param_mode_i, param_sel_i} = {1'b1, 8'h06};
    disp("mask", {B, 5'h0, 5'h0, 5'h0, 5'h1}, 5'h00);
    wr(1'b0, 16'h0197);
    chk("ignored", forced_mode_o, 1'b1);
    wr(1'b0, 16'h0190);
    chk("normal", {forced_mode_o, output_line_o}, 3'b010);
  endtask
  task automatic t_panel();
    {diag_mode_i, param_sel_i} = {2'h0, 8'h02};
    press(0);
    chk("fidx", fault_index_o, 3'h2);
    disp("fault", {B, 5'ha, 5'hb, 5'hc, 5'hd}, 5'h00);
    press(3);
    param_sel_i = 8'h05;
    press(0);
    chk("jog_spd", jog_speed_o, 16'h0014);
    press(1);
    chk("jog_up", jog_speed_o, 16'h0015);
    press(0);
    chk("jog_sym", jog_symbol_o, 1'b1);
    kp.put(1, 1'b1);
    chk("no_servo", jog_fwd_o, 1'b0);
    kp.put(1, 1'b0);
    servo_on_i = 1'b1;
    kp.put(2, 1'b1);
    chk("rev", {jog_fwd_o, jog_rev_o}, 2'b01);
    kp.put(2, 1'b0);
    chk("rev_stop", jog_rev_o, 1'b0);
    kp.put(1, 1'b1);
    chk("fwd", {jog_fwd_o, jog_rev_o}, 2'b10);
    kp.put(1, 1'b0);
    chk("fwd_stop", jog_fwd_o, 1'b0);
    press(3);
    chk("jog_exit", jog_symbol_o, 1'b0);
    param_mode_i = 1'b0;
    press(2);
    chk("msel_dn", monitor_sel_o, 8'h19);
    press(1);
    chk("msel_up", monitor_sel_o, 8'h1a);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {reset_n_i, servo_on_i, param_mode_i, edit_active_i, edit_is32_i, edit_hex_i, view_hex_i} = 7'h00;
    {view_high_i, cmd_wr_i, mask_wr_i, diag_mode_i, param_sel_i, cmd_value_i, mask_value_i} = 45'h0;
    {input_line_i, normal_do_i, resonance_one_i, resonance_two_i} = {5'h1e, 2'b11, 8'h34, 8'h12};
    {fault_record_i, inertia_x10_i, edit_value_i} = {16'habcd, 16'h0082, 32'h000004d2};
    {encoder_index_pulse_i, misc_value_i} = {32'h499602d2, 32'h00000016};
    {mapping_value_one_i, mapping_value_two_i, mapping_value_three_i} = {32'h12340013, 32'h12340014, 32'h12340015};
    {monitor_value_one_i, monitor_value_two_i} = {32'h12340017, 32'h12340018};
    {monitor_value_three_i, monitor_value_four_i} = {32'h12340019, 32'h1234001a};
    t_monitor();
    t_edit();
    t_force();
    t_panel();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule
